/* File: common/reclose_pkg.sv */
package reclose_pkg;

   // Shot numbering and counter widths.
   localparam int NUM_SHOTS = 5;
   localparam int NUM_REQ_LINES = 4;
   localparam int NUM_CNT_LINES = 2;
   localparam int CNT_W = 16;
   localparam int TIME_W = 24;
   localparam logic [2:0] FIRST_SHOT = 3'h1;

   // Timer base: interval settings are given in ticks of 10 ms.
   localparam int CLK_HZ = 20000000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

   // Reclaim interval limits in ticks: 0.02 s to 300 s.
   localparam logic [TIME_W-1:0] RECLAIM_MIN = 24'h000002;
   localparam logic [TIME_W-1:0] RECLAIM_MAX = 24'h007530;

   // Sequencer state, reported to software.
   typedef enum logic [9:0] {
      ST_INIT = 10'h001,
      ST_RECLAIM = 10'h002,
      ST_READY = 10'h004,
      ST_WAIT_OPEN = 10'h008,
      ST_WAIT_CLOSE = 10'h010,
      ST_DISCRIM = 10'h020,
      ST_LOCKED = 10'h040,
      ST_FINAL_TRIP = 10'h080,
      ST_BRK_FAIL = 10'h100,
      ST_INHIBIT = 10'h200
   } seq_state_t;

   // Breaker object state.
   typedef enum logic [3:0] {
      BRK_UNDEF = 4'h0,
      BRK_OPEN = 4'h1,
      BRK_CLOSED = 4'h2,
      BRK_OPEN_REQ = 4'h3,
      BRK_CLOSE_REQ = 4'h4,
      BRK_READY = 4'h5,
      BRK_NOT_READY = 4'h6,
      BRK_NO_INFO = 4'h7,
      BRK_FAILED = 4'h8
   } brk_state_t;

   // Which interval timer is running.
   typedef enum logic [1:0] {
      TM_RECLAIM = 2'h0,
      TM_START = 2'h1,
      TM_DEAD = 2'h2,
      TM_DISCRIM = 2'h3
   } timer_kind_t;

   // Logic node functions; AND is the code after reset.
   typedef enum logic [2:0] {
      FN_AND = 3'h0,
      FN_OR = 3'h1,
      FN_XOR = 3'h2,
      FN_NOT = 3'h3,
      FN_COUNT = 3'h4,
      FN_RS = 3'h5,
      FN_D = 3'h6
   } node_fn_t;

endpackage

/* File: design/auto_reclose_sequencer.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Report active shot index one to five.
// - Per-shot counters per line, total, failed counts.
// - Overcurrent starts shot one start delay.
// - Start delay expiry asserts trip output.
// - Breaker open releases trip, starts dead interval.
// - Dead interval expiry asserts close output.
// - Breaker closed releases close, starts discrimination.
// - Current persists after discrimination: trip, next shot; after the last shot, final trip and lockout.
// - Later shots use their own dead interval.
// - Current gone: time reclaim; no counter steps.
// - After reclaim return ready at shot one.
// - Logic nodes offer gates, counter, flip-flops.
// - New logic node defaults to AND.
// - Counter node uses programmable count value.
// - Separate on and off delays per node.
// - Optional output inversion per node.
// - Restart after loading; outputs routed automatically.
// - One reclaim interval, 0.02 to 300 s.
// - Per-shot enable for each request line; only shot one's enables gate a start.
// - Close withheld while block input active.
////////////////////////////////////////////////////////////////////////////
module auto_reclose_sequencer #(
   parameter int SHOTS = reclose_pkg::NUM_SHOTS,
   parameter int NODES = 4,
   parameter int NODE_IN = 4,
   parameter int TICK_CYCLES = reclose_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic autoRecloseEnable,
   input wire logic [reclose_pkg::NUM_REQ_LINES-1:0] recloseRequestLine,
   input wire logic overCurrent,
   input wire logic breakerOpen,
   input wire logic breakerClosed,
   input wire logic closeBlockInput,
   input wire logic [SHOTS*reclose_pkg::NUM_REQ_LINES-1:0] shotLineEnable,
   input wire logic [SHOTS*reclose_pkg::TIME_W-1:0] deadInterval,
   input wire logic [SHOTS*reclose_pkg::TIME_W-1:0] startDelay,
   input wire logic [SHOTS*reclose_pkg::TIME_W-1:0] discrimInterval,
   input wire logic [reclose_pkg::TIME_W-1:0] reclaimInterval,
   input wire logic [reclose_pkg::TIME_W-1:0] breakerTimeout,
   input wire logic [NODES*NODE_IN-1:0] nodeInputs,
   input wire logic [NODES*NODE_IN-1:0] nodeInUsed,
   input wire logic [NODES*3-1:0] nodeFunction,
   input wire logic [NODES*16-1:0] nodeCount,
   input wire logic [NODES*16-1:0] nodeOnDelay,
   input wire logic [NODES*16-1:0] nodeOffDelay,
   input wire logic [NODES-1:0] nodeInvert,
   output logic breakerTripOutput,
   output logic breakerCloseOutput,
   output reclose_pkg::seq_state_t sequencerState,
   output reclose_pkg::brk_state_t breakerObjectState,
   output reclose_pkg::timer_kind_t runningTimer,
   output logic [2:0] activeShot,
   output logic [reclose_pkg::CNT_W-1:0] totalStartCount,
   output logic [reclose_pkg::CNT_W-1:0] failedShotCount,
   output logic [SHOTS*reclose_pkg::NUM_CNT_LINES*reclose_pkg::CNT_W-1:0]
      perShotStartCount,
   output logic [NODES-1:0] outputMatrix
);
   import reclose_pkg::*;

   initial begin
      if (SHOTS < 1 || SHOTS > 7 || NODES < 1 || TICK_CYCLES < 1) begin
         $error("unsupported sequencer parameters");
      end
   end

   localparam int CW = CNT_W;
   localparam int LINES = NUM_CNT_LINES;

   typedef struct packed {
      seq_state_t state;
      brk_state_t brk;
      timer_kind_t tkind;
      logic [2:0] shot;
      logic [TIME_W-1:0] timer;
      logic [1:0] line;
      logic trip;
      logic close;
      logic [CW-1:0] total;
      logic [CW-1:0] failed;
      logic [SHOTS*LINES*CW-1:0] perShot;
      logic [NODES-1:0] matrix;
   } seq_reg_t;

   seq_reg_t r;
   seq_reg_t next_r;
   logic tick;
   logic [NODES-1:0] nodeOut;
   logic [NUM_REQ_LINES-1:0] lineEn;
   logic [TIME_W-1:0] deadSel;
   logic [TIME_W-1:0] startSel;
   logic [TIME_W-1:0] discrSel;
   logic [TIME_W-1:0] reclaimSel;
   logic [2:0] shotIdx;
   logic timerDone;

   ////////////////////////////////////////////////////////////////////////
   // Timer tick and logic engine.
   interval_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk(clk),
      .srst(srst),
      .tick(tick)
   );

   genvar g;
   generate
      for (g = 0; g < NODES; g++) begin : g_node
         logic_node #(.NIN(NODE_IN), .DW(16)) u_node (
            .clk(clk),
            .srst(srst),
            .tick(tick),
            .nodeIn(nodeInputs[g*NODE_IN +: NODE_IN]),
            .nodeInUsed(nodeInUsed[g*NODE_IN +: NODE_IN]),
            .nodeFn(node_fn_t'(nodeFunction[g*3 +: 3])),
            .countSetting(nodeCount[g*16 +: 16]),
            .onDelay(nodeOnDelay[g*16 +: 16]),
            .offDelay(nodeOffDelay[g*16 +: 16]),
            .invertOut(nodeInvert[g]),
            .nodeOut(nodeOut[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Per-shot settings of the active shot.
   assign shotIdx = r.shot - FIRST_SHOT;
   assign lineEn = shotLineEnable[shotIdx*NUM_REQ_LINES +: NUM_REQ_LINES];
   assign deadSel = deadInterval[shotIdx*TIME_W +: TIME_W];
   assign startSel = startDelay[shotIdx*TIME_W +: TIME_W];
   assign discrSel = discrimInterval[shotIdx*TIME_W +: TIME_W];
   assign timerDone = (r.timer == '0);

   // Clamp the common reclaim interval into its legal range.
   always_comb begin
      if (reclaimInterval < RECLAIM_MIN) begin
         reclaimSel = RECLAIM_MIN;
      end else if (reclaimInterval > RECLAIM_MAX) begin
         reclaimSel = RECLAIM_MAX;
      end else begin
         reclaimSel = reclaimInterval;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer next state.
   always_comb begin
      next_r = r;
      next_r.matrix = nodeOut;
      if (tick && !timerDone) begin
         next_r.timer = r.timer - 1'b1;
      end
      // Breaker object follows the status contacts and the commands.
      if (breakerOpen && breakerClosed) begin
         next_r.brk = BRK_FAILED;
      end else if (r.trip) begin
         next_r.brk = BRK_OPEN_REQ;
      end else if (r.close) begin
         next_r.brk = BRK_CLOSE_REQ;
      end else if (breakerOpen) begin
         next_r.brk = BRK_OPEN;
      end else if (breakerClosed) begin
         next_r.brk = BRK_CLOSED;
      end else begin
         next_r.brk = BRK_UNDEF;
      end
      unique case (r.state)
         ST_INIT: begin
            next_r.state = autoRecloseEnable ? ST_READY : ST_INHIBIT;
         end
         ST_INHIBIT: begin
            if (autoRecloseEnable) begin
               next_r.state = ST_READY;
            end
         end
         ST_READY: begin
            next_r.shot = FIRST_SHOT;
            if (!autoRecloseEnable) begin
               next_r.state = ST_INHIBIT;
            end else if (overCurrent && r.tkind != TM_START &&
                         |(recloseRequestLine & lineEn)) begin
               next_r.tkind = TM_START;
               next_r.timer = startSel;
               next_r.line = recloseRequestLine[0] ? 2'h0 : 2'h1;
            end else if (r.tkind == TM_START && !overCurrent) begin
               next_r.tkind = TM_RECLAIM;
            end else if (r.tkind == TM_START && timerDone) begin
               next_r.trip = 1'b1;
               next_r.total = r.total + 1'b1;
               next_r.perShot[r.line*CW +: CW] =
                  r.perShot[r.line*CW +: CW] + 1'b1;
               next_r.timer = breakerTimeout;
               next_r.state = ST_WAIT_OPEN;
            end
         end
         ST_WAIT_OPEN: begin
            if (breakerOpen) begin
               next_r.trip = 1'b0;
               next_r.tkind = TM_DEAD;
               next_r.timer = deadSel;
               next_r.state = ST_WAIT_CLOSE;
            end else if (timerDone) begin
               next_r.trip = 1'b0;
               next_r.state = ST_BRK_FAIL;
            end
         end
         ST_WAIT_CLOSE: begin
            if (!r.close && timerDone) begin
               if (!closeBlockInput) begin
                  next_r.close = 1'b1;
                  next_r.timer = breakerTimeout;
               end
            end else if (r.close && breakerClosed) begin
               next_r.close = 1'b0;
               next_r.tkind = TM_DISCRIM;
               next_r.timer = discrSel;
               next_r.state = ST_DISCRIM;
            end else if (r.close && timerDone) begin
               next_r.close = 1'b0;
               next_r.state = ST_BRK_FAIL;
            end
         end
         ST_DISCRIM: begin
            if (!overCurrent) begin
               next_r.tkind = TM_RECLAIM;
               next_r.timer = reclaimSel;
               next_r.state = ST_RECLAIM;
            end else if (timerDone) begin
               next_r.failed = r.failed + 1'b1;
               next_r.trip = 1'b1;
               next_r.timer = breakerTimeout;
               if (r.shot == 3'(SHOTS)) begin
                  next_r.state = ST_FINAL_TRIP;
               end else begin
                  next_r.shot = r.shot + 1'b1;
                  next_r.total = r.total + 1'b1;
                  next_r.perShot[(shotIdx + 3'h1)*LINES*CW + r.line*CW
                                 +: CW] =
                     r.perShot[(shotIdx + 3'h1)*LINES*CW + r.line*CW
                               +: CW] + 1'b1;
                  next_r.state = ST_WAIT_OPEN;
               end
            end
         end
         ST_RECLAIM: begin
            if (overCurrent || timerDone) begin
               next_r.shot = FIRST_SHOT;
               next_r.state = ST_READY;
               next_r.tkind = TM_RECLAIM;
            end
         end
         ST_FINAL_TRIP: begin
            if (breakerOpen) begin
               next_r.trip = 1'b0;
               next_r.state = ST_LOCKED;
            end
         end
         ST_LOCKED, ST_BRK_FAIL: begin
            // Held until cleared by disabling the function.
            if (!autoRecloseEnable) begin
               next_r.state = ST_INHIBIT;
            end
         end
      endcase
   end

   // Register the state.
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '0;
         r.state <= ST_INIT;
         r.brk <= BRK_UNDEF;
         r.shot <= FIRST_SHOT;
         r.tkind <= TM_RECLAIM;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register.
   assign breakerTripOutput = r.trip;
   assign breakerCloseOutput = r.close;
   assign sequencerState = r.state;
   assign breakerObjectState = r.brk;
   assign runningTimer = r.tkind;
   assign activeShot = r.shot;
   assign totalStartCount = r.total;
   assign failedShotCount = r.failed;
   assign perShotStartCount = r.perShot;
   assign outputMatrix = r.matrix;
endmodule

/* File: design/interval_tick.sv */
`timescale 1ns/100ps
// Free-running prescaler giving one pulse per timer tick.
module interval_tick #(
   parameter int CYCLES = reclose_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   output logic tick
);
   import reclose_pkg::*;

   initial begin
      if (CYCLES < 1) begin
         $error("tick period must be at least one cycle");
      end
   end

   typedef struct packed {
      logic [31:0] count;
      logic tick;
   } tick_reg_t;

   tick_reg_t r;
   tick_reg_t next_r;

   // Count down and pulse at the wrap.
   always_comb begin
      next_r = r;
      next_r.tick = 1'b0;
      if (r.count == 32'h0) begin
         next_r.count = 32'(CYCLES - 1);
         next_r.tick = 1'b1;
      end else begin
         next_r.count = r.count - 32'h1;
      end
   end

   // Register the state.
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign tick = r.tick;
endmodule

/* File: design/logic_node.sv */
`timescale 1ns/100ps
// One programmable boolean node with on and off delays and inversion.
module logic_node #(
   parameter int NIN = 4,
   parameter int DW = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic tick,
   input wire logic [NIN-1:0] nodeIn,
   input wire logic [NIN-1:0] nodeInUsed,
   input wire reclose_pkg::node_fn_t nodeFn,
   input wire logic [DW-1:0] countSetting,
   input wire logic [DW-1:0] onDelay,
   input wire logic [DW-1:0] offDelay,
   input wire logic invertOut,
   output logic nodeOut
);
   import reclose_pkg::*;

   initial begin
      if (NIN < 2 || DW < 1) begin
         $error("logic node needs two inputs and a delay width");
      end
   end

   typedef struct packed {
      logic [DW-1:0] count;
      logic [DW-1:0] delay;
      logic [1:0] prevIn;
      logic mem;
      logic out;
   } node_reg_t;

   node_reg_t r;
   node_reg_t next_r;
   logic [NIN-1:0] andIn;
   logic raw;

   // Unused inputs are neutral: high for AND, low for OR and XOR.
   assign andIn = nodeIn | ~nodeInUsed;

   // Evaluate the function, then delay each output edge separately.
   always_comb begin
      next_r = r;
      next_r.prevIn = nodeIn[1:0];
      unique case (nodeFn)
         FN_OR: raw = |(nodeIn & nodeInUsed);
         FN_XOR: raw = ^(nodeIn & nodeInUsed);
         FN_NOT: raw = ~nodeIn[0];
         FN_COUNT: begin
            // Input 0 counts rising edges, input 1 clears.
            if (nodeIn[1]) begin
               next_r.count = '0;
            end else if (nodeIn[0] && !r.prevIn[0] && r.count != countSetting) begin
               next_r.count = r.count + 1'b1;
            end
            raw = (r.count == countSetting);
         end
         FN_RS: begin
            // Input 0 sets, input 1 resets, reset dominant.
            if (nodeIn[1]) begin
               next_r.mem = 1'b0;
            end else if (nodeIn[0]) begin
               next_r.mem = 1'b1;
            end
            raw = r.mem;
         end
         FN_D: begin
            // Input 1 rising edge captures input 0.
            if (nodeIn[1] && !r.prevIn[1]) begin
               next_r.mem = nodeIn[0];
            end
            raw = r.mem;
         end
         default: raw = &andIn;
      endcase
      if (invertOut) begin
         raw = ~raw;
      end
      if (raw == r.out) begin
         next_r.delay = '0;
      end else if ((raw ? onDelay : offDelay) <= r.delay) begin
         next_r.out = raw;
         next_r.delay = '0;
      end else if (tick) begin
         next_r.delay = r.delay + 1'b1;
      end
   end

   // Register the state.
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign nodeOut = r.out;
endmodule

/* File: verification/auto_reclose_sequencer_chk.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Checks sequencer outputs against their causes at the inputs.
module auto_reclose_sequencer_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic breakerOpen,
   input wire logic breakerClosed,
   input wire logic closeBlockInput,
   input wire logic breakerTripOutput,
   input wire logic breakerCloseOutput,
   input wire reclose_pkg::seq_state_t sequencerState,
   input wire reclose_pkg::brk_state_t breakerObjectState,
   input wire reclose_pkg::timer_kind_t runningTimer,
   input wire logic [2:0] activeShot,
   input wire logic [reclose_pkg::CNT_W-1:0] totalStartCount,
   input wire logic [reclose_pkg::CNT_W-1:0] failedShotCount
);
   import reclose_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////
   // Reported values stay inside their defined sets.
   shot_range_a: assert property (activeShot >= 3'h1 && activeShot <= 3'h5)
      else $error("Active shot out of range.");
   state_onehot_a: assert property ($onehot(sequencerState))
      else $error("Sequencer state not one-hot.");
   brk_code_a: assert property (breakerObjectState <= BRK_FAILED)
      else $error("Breaker state code undefined.");
   ready_shot_a: assert property (sequencerState == ST_READY |-> activeShot == FIRST_SHOT)
      else $error("Ready without shot one.");
   ////////////////////////////////////////////////////////////////////////
   // Counters only step up by one, a reset excepted.
   start_step_a: assert property (!$past(srst) && $changed(totalStartCount) |-> totalStartCount == $past(totalStartCount) + 16'h0001)
      else $error("Start count jumped.");
   fail_step_a: assert property (!$past(srst) && $changed(failedShotCount) |-> failedShotCount == $past(failedShotCount) + 16'h0001)
      else $error("Failed count jumped.");
   ////////////////////////////////////////////////////////////////////////
   // Breaker handshake order.
   trip_open_a: assert property (breakerTripOutput && breakerOpen && sequencerState == ST_WAIT_OPEN |=> !breakerTripOutput && runningTimer == TM_DEAD)
      else $error("Trip not released into dead interval.");
   close_dead_a: assert property ($rose(breakerCloseOutput) |-> runningTimer == TM_DEAD)
      else $error("Close without dead interval.");
   close_done_a: assert property (breakerCloseOutput && breakerClosed |=> !breakerCloseOutput && sequencerState == ST_DISCRIM)
      else $error("Close not released into discrimination.");
   close_block_a: assert property ($rose(breakerCloseOutput) |-> !$past(closeBlockInput))
      else $error("Close issued while blocked.");
endmodule
bind auto_reclose_sequencer auto_reclose_sequencer_chk auto_reclose_sequencer_chk_i (
   .clk(clk), .srst(srst), .breakerOpen(breakerOpen),
   .breakerClosed(breakerClosed), .closeBlockInput(closeBlockInput),
   .breakerTripOutput(breakerTripOutput),
   .breakerCloseOutput(breakerCloseOutput), .sequencerState(sequencerState),
   .breakerObjectState(breakerObjectState), .runningTimer(runningTimer),
   .activeShot(activeShot), .totalStartCount(totalStartCount),
   .failedShotCount(failedShotCount));

/* File: verification/auto_reclose_sequencer_tb.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Self-checking bench: reclose sequences against a breaker model.
module auto_reclose_sequencer_tb;
   import reclose_pkg::*;
   localparam int TC = 2;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] recloseRequestLine = 4'h0;
   logic overCurrent = 1'b0;
   logic closeBlockInput = 1'b0;
   logic [19:0] shotLineEnable = 20'hFFFF0;
   logic [119:0] deadInterval = 120'h0;
   logic [15:0] nodeInputs = 16'h0000, nodeInUsed = 16'hFFFF;
   logic [11:0] nodeFunction = 12'h000;
   logic [63:0] nodeDelay = 64'h0;
   logic [3:0] nodeInvert = 4'h0;
   logic breakerOpen, breakerClosed, breakerTripOutput, breakerCloseOutput;
   seq_state_t sequencerState;
   brk_state_t breakerObjectState;
   timer_kind_t runningTimer;
   logic [2:0] activeShot;
   logic [15:0] totalStartCount, failedShotCount;
   logic [159:0] perShotStartCount;
   logic [3:0] outputMatrix;
   int failures = 0, cmpCount = 0, expTotal = 0, expFail = 0;
   int expShot [10] = '{default: 0};

   auto_reclose_sequencer #(.TICK_CYCLES(TC)) auto_reclose_sequencer_i (
      .clk(clk), .srst(srst), .autoRecloseEnable(1'b1),
      .recloseRequestLine(recloseRequestLine), .overCurrent(overCurrent),
      .breakerOpen(breakerOpen), .breakerClosed(breakerClosed),
      .closeBlockInput(closeBlockInput), .shotLineEnable(shotLineEnable),
      .deadInterval(deadInterval), .startDelay({5{24'h000002}}),
      .discrimInterval({5{24'h000008}}), .reclaimInterval(24'h000005),
      .breakerTimeout(24'h000200), .nodeInputs(nodeInputs),
      .nodeInUsed(nodeInUsed), .nodeFunction(nodeFunction),
      .nodeCount({4{16'h0003}}), .nodeOnDelay(nodeDelay),
      .nodeOffDelay(nodeDelay), .nodeInvert(nodeInvert),
      .breakerTripOutput(breakerTripOutput),
      .breakerCloseOutput(breakerCloseOutput),
      .sequencerState(sequencerState),
      .breakerObjectState(breakerObjectState),
      .runningTimer(runningTimer), .activeShot(activeShot),
      .totalStartCount(totalStartCount), .failedShotCount(failedShotCount),
      .perShotStartCount(perShotStartCount), .outputMatrix(outputMatrix));

   breaker_model breaker_model_i (
      .clk(clk), .tripCmd(breakerTripOutput), .closeCmd(breakerCloseOutput),
      .lag(8'h03), .breakerOpen(breakerOpen), .breakerClosed(breakerClosed));

   // Clock of 50 ns.
   always #25 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // Compares and counts; a mismatch is reported at once.
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string msg);
      cmpCount++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: %s got %0h expected %0h", $time, msg, got, exp);
      end
   endtask

   // Lets edges pass, then steps just past the last one.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // True when a measured span is close to the expected tick count.
   function automatic logic near(input int m, input int ticks);
      return (m >= ticks * TC - 2) && (m <= ticks * TC + 2 * TC + 2);
   endfunction

   // Expected output of one node before inversion.
   function automatic logic nodeExp(input int f, input logic [3:0] a);
      case (f)
         0: return &a;
         1: return |a;
         2: return ^a;
         default: return !a[0];
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // One fault: nFail shots fail discrimination, then the fault clears unless all five shots fail.
   task automatic runSeq(input int nFail, input bit block);
      int m, line, last;
      line = $urandom % 2;
      last = (nFail >= 5) ? 5 : nFail + 1;
      overCurrent = 1'b1;
      recloseRequestLine = 4'h1 << line;
      for (int s = 1; s <= last; s++) begin
         for (m = 0; !breakerTripOutput && m < 500; m++) tick(1);
         check(near(m, (s == 1) ? 2 : 8), 1, "trip delay");
         check(activeShot, s, "shot index");
         expTotal++;
         expShot[(s - 1) * 2 + line]++;
         for (m = 0; breakerTripOutput && m < 500; m++) tick(1);
         if (block) begin
            closeBlockInput = 1'b1;
            tick(deadInterval[(s - 1) * 24 +: 24] * TC + 20);
            check(breakerCloseOutput, 0, "close withheld");
            closeBlockInput = 1'b0;
            tick(1);
            check(breakerCloseOutput, 1, "close after block");
         end else begin
            for (m = 0; !breakerCloseOutput && m < 500; m++) tick(1);
            check(near(m, deadInterval[(s - 1) * 24 +: 24]), 1, "dead");
         end
         for (m = 0; breakerCloseOutput && m < 500; m++) tick(1);
         if (s > nFail) overCurrent = 1'b0;
         else expFail++;
      end
      if (nFail >= 5) begin
         for (m = 0; sequencerState !== ST_LOCKED && m < 900; m++) tick(1);
         check(sequencerState, ST_LOCKED, "locked after last shot");
      end else begin
         for (m = 0; sequencerState !== ST_RECLAIM && m < 900; m++) tick(1);
         for (m = 0; sequencerState === ST_RECLAIM && m < 900; m++) tick(1);
         check(near(m, 5), 1, "reclaim span");
         check(sequencerState, ST_READY, "ready again");
         check(activeShot, FIRST_SHOT, "shot one");
      end
      check(totalStartCount, expTotal, "total starts");
      check(failedShotCount, expFail, "failed shots");
      for (int i = 0; i < 10; i++)
         check(perShotStartCount[i * 16 +: 16], expShot[i], "shot starts");
      tick(4);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      logic [3:0] a;
      void'($urandom(84));
      for (int s = 0; s < 5; s++)
         deadInterval[s * 24 +: 24] = 24'(3 + 8 * s + $urandom % 3);
      tick(3);
      check(sequencerState, ST_INIT, "reset state");
      check(activeShot, FIRST_SHOT, "reset shot");
      check(totalStartCount, 0, "reset count");
      srst = 1'b0;
      tick(4);
      // Gates with random inputs, plain and inverted.
      for (int f = 0; f < 4; f++) begin
         for (int k = 0; k < 4; k++) begin
            a = 4'($urandom);
            nodeFunction[2:0] = 3'(f);
            nodeInUsed[3:0] = (f == 3) ? 4'h1 : 4'hF;
            nodeInvert[0] = k[0];
            nodeInputs[3:0] = a;
            tick(6);
            check(outputMatrix[0], nodeExp(f, a) ^ k[0], "node");
         end
      end
      // Counter node, then on and off delays of eight ticks on an OR node.
      nodeInvert[0] = 1'b0;
      nodeFunction[2:0] = FN_COUNT;
      for (int k = 0; k < 7; k++) begin
         nodeInputs[3:0] = 4'(k % 2);
         tick(3);
         check(outputMatrix[0], k >= 5, "counter node");
      end
      nodeFunction[2:0] = FN_OR;
      nodeInputs[3:0] = 4'h0;
      nodeInUsed[3:0] = 4'hF;
      tick(40);
      nodeDelay[15:0] = 16'h0008;
      srst = 1'b1;
      tick(1);
      srst = 1'b0;
      nodeInputs[3:0] = 4'h2;
      tick(6);
      check(outputMatrix[0], 0, "on delay early");
      tick(20);
      check(outputMatrix[0], 1, "on delay done");
      nodeInputs[3:0] = 4'h0;
      tick(6);
      check(outputMatrix[0], 1, "off delay early");
      tick(20);
      check(outputMatrix[0], 0, "off delay done");
      // A request on a line not enabled for shot one starts nothing.
      overCurrent = 1'b1;
      recloseRequestLine = 4'h1;
      tick(40);
      check(breakerTripOutput, 0, "line disabled");
      overCurrent = 1'b0;
      recloseRequestLine = 4'h0;
      shotLineEnable = 20'hFFFFF;
      tick(4);
      runSeq(0, 1'b1);
      runSeq(1, 1'b0);
      runSeq(2 + $urandom % 2, 1'b0);
      runSeq(5, 1'b0);
      summarize();
   end

   // Cuts a hang short well beyond the expected run time.
   initial begin
      #3000000;
      failures++;
      summarize();
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmpCount, failures);
      if (failures == 0 && cmpCount > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
endmodule

/* File: verification/breaker_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// Breaker: contacts follow an energised coil after a settable lag.
module breaker_model (
   input wire logic clk,
   input wire logic tripCmd,
   input wire logic closeCmd,
   input wire logic [7:0] lag,
   output logic breakerOpen,
   output logic breakerClosed
);
   logic [7:0] hold = 8'h00;
   logic isOpen = 1'b0;
   // Both contacts follow one state; the breaker starts closed.
   assign breakerOpen = isOpen;
   assign breakerClosed = !isOpen;
   // A coil that stays energised for lag + 1 cycles moves the contacts.
   always @(posedge clk) begin
      if ((tripCmd && breakerClosed) || (closeCmd && breakerOpen)) begin
         hold <= hold + 8'h01;
         if (hold >= lag) begin
            isOpen <= tripCmd;
            hold <= 8'h00;
         end
      end else begin
         hold <= 8'h00;
      end
   end
endmodule
